// ===== pcbs_pkg.sv
package pcbs_pkg;
   // ************************************************************
   // Address widths and fixed locations
   // ************************************************************
   localparam int PC_W = 17;
   localparam int RAM_AW = 16;
   localparam int RAM_DW = 9;
   localparam logic [16:0] RESET_VEC_LOW = 17'h00000;
   localparam logic [16:0] RESET_VEC_ALT = 17'h01e00;
   localparam logic [16:0] IRQ_VEC_BASE = 17'h00003;
   localparam logic [16:0] IRQ_VEC_STEP = 17'h00008;
   localparam int IRQ_NUM = 10;
   localparam logic [15:0] ACC_ADDR = 16'hfe00;
   localparam logic [15:0] RAM9_TOP = 16'hfdff;
   localparam logic [15:0] IND_REG_TOP = 16'h007f;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [16:0] OPT_AREA_LO = 17'h01f00;
   localparam logic [16:0] OPT_AREA_HI = 17'h01fff;
   localparam int PSW_NINTH_BIT = 1;

   // ************************************************************
   // Sequencer operations
   // ************************************************************
   typedef enum logic [3:0] {
      PCBS_OP_NONE,
      PCBS_OP_STEP,
      PCBS_OP_BRANCH,
      PCBS_OP_JUMP_ABS,
      PCBS_OP_CALL_ABS,
      PCBS_OP_JUMP_REL,
      PCBS_OP_CALL_REL,
      PCBS_OP_CALL_ACC,
      PCBS_OP_RETURN,
      PCBS_OP_IRQ
   } pcbs_op_type;

   typedef struct packed {
      pcbs_op_type op;
      logic [2:0] nbytes;
      logic [7:0] disp8;
      logic [11:0] disp12;
      logic [16:0] target;
      logic [3:0] irq_idx;
      logic taken;
   } pcbs_cmd_type;

   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [8:0] wdata;
   } pcbs_ram_req_type;
endpackage : pcbs_pkg

// ===== pcbs_sequencer.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// Contract
// [RQ1] Instruction address is 17 bits plus a separate bank flag.
// [RQ2] Plain instructions advance by byte count, bank unchanged.
// [RQ3] Reset loads bank 0 and start 00000H or 01E00H by option.
// [RQ4] Accepted interrupt loads its bank 0 vector, eight bytes apart.
// [RQ5] Taken conditional branch: next address plus signed 8-bit displacement.
// [RQ6] Return takes high bits from stack top, low and bank below.
// [RQ7] Software changes bank only by pushing target then returning.
// [RQ8] Bank 0 01F00H to 01FFFH is option data, no code.
// [RQ9] Table lookup pair is 17 bits, confined to current bank.
// [RQ10] Data RAM below FE00H is nine bits, ninth bit via status bit 1.
// [RQ11] RAM 0000H to 007FH forms 64 two-byte indirect registers.
// [RQ12] Call pushes bank and low byte at +1, high nine at +2.
// [RQ13] Eight-bit accumulator at FE00H, cleared by reset.
// [RQ14] Absolute, relative and accumulator-indexed jumps and calls keep bank; there is no accumulator-indexed jump, only the call.
module pcbs_sequencer import pcbs_pkg::*; #(
   parameter bit HAS_START_OPTION = 1'b1
) (
   input wire logic ref_clk, // Core clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state when low
   input wire logic start_opt, // Stored start option: 1 selects alternate start
   input wire pcbs_cmd_type cmd, // Sequencing command, one per cycle
   input wire logic [8:0] ram_rdata, // Stack RAM word, valid one cycle after read
   input wire logic [5:0] lookup_reg, // Indirect register index for lookup
   input wire logic [15:0] bus_addr, // Register bus address
   input wire logic [7:0] bus_wdata, // Register bus write data
   input wire logic bus_wr, // Register bus write strobe
   input wire logic bus_rd, // Register bus read strobe
   input wire logic [16:0] lookup_pair, // Nine high plus eight low pair bits
   output logic [7:0] bus_rdata, // Read data, cycle after read strobe
   output logic [16:0] pc, // Instruction address
   output logic bank_flag, // Current bank
   output pcbs_ram_req_type ram_req, // Stack RAM request
   output logic ram_rd, // Stack RAM read strobe
   output logic busy, // Multi-cycle push or pop in progress
   output logic [17:0] rom_lookup_addr, // Bank plus 17-bit lookup address
   output logic [15:0] lookup_ram_addr, // RAM address of the lookup pair low byte
   output logic [7:0] accumulator // Accumulator contents
);
   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PUSH_LOW,
      ST_PUSH_HIGH,
      ST_POP_HIGH,
      ST_POP_LOW,
      ST_POP_DONE
   } pcbs_state_type;

   pcbs_state_type state_r;
   logic [16:0] pc_r;
   logic bank_r;
   logic [15:0] sp_r;
   logic [16:0] ret_addr_r;
   logic [16:0] tgt_r;
   logic [8:0] high_r;
   logic [7:0] acc_r;
   logic [7:0] rdata_r;
   pcbs_ram_req_type req_r;
   logic rd_r;
   logic [17:0] look_r;
   logic [15:0] look_ram_r;
   logic [16:0] pc_nxt;
   logic [16:0] vec_tab [IRQ_NUM];
   logic busy_r;
   logic irq_bank_clr_r;
   logic start_done_r;

   // Elaboration guard: the stack frame layout assumes a 17-bit address
   if (PC_W != 17) begin : g_width_check
      $error("Program counter width must be 17");
   end

   // ************************************************************
   // Interrupt vector table
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < IRQ_NUM; gi++) begin : g_vec
         assign vec_tab[gi] = IRQ_VEC_BASE + 17'(gi) * IRQ_VEC_STEP; // RQ4
      end
   endgenerate

   // ************************************************************
   // Next address
   // ************************************************************
   always_comb begin
      pc_nxt = pc_r + 17'(cmd.nbytes); // RQ2
      case (cmd.op)
         PCBS_OP_BRANCH: begin
            if (cmd.taken) begin
               pc_nxt = pc_r + 17'(cmd.nbytes) + {{9{cmd.disp8[7]}}, cmd.disp8}; // RQ5
            end
         end
         PCBS_OP_JUMP_ABS, PCBS_OP_CALL_ABS: pc_nxt = cmd.target; // RQ14
         PCBS_OP_JUMP_REL, PCBS_OP_CALL_REL: begin
            pc_nxt = pc_r + 17'h00002 + {{5{cmd.disp12[11]}}, cmd.disp12}; // RQ14
         end
         PCBS_OP_CALL_ACC: pc_nxt = pc_r + 17'h00001 + {9'h000, acc_r}; // RQ14
         default: pc_nxt = pc_r + 17'(cmd.nbytes);
      endcase
   end

   // ************************************************************
   // Program counter and stack sequencing
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         pc_r <= RESET_VEC_LOW;
         bank_r <= 1'b0;
         sp_r <= 16'h0000;
         ret_addr_r <= 17'h00000;
         tgt_r <= 17'h00000;
         high_r <= 9'h000;
         req_r <= '0;
         rd_r <= 1'b0;
         busy_r <= 1'b0;
      end else if (clk_en) begin
         req_r.we <= 1'b0;
         rd_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               case (cmd.op)
                  PCBS_OP_NONE: pc_r <= pc_r;
                  PCBS_OP_CALL_ABS, PCBS_OP_CALL_REL, PCBS_OP_CALL_ACC: begin
                     ret_addr_r <= pc_r + 17'(cmd.nbytes);
                     tgt_r <= pc_nxt;
                     busy_r <= 1'b1;
                     state_r <= ST_PUSH_LOW;
                  end
                  PCBS_OP_IRQ: begin
                     ret_addr_r <= pc_r;
                     // Unused indices fall back to the first vector, never to X
                     if (cmd.irq_idx < 4'(IRQ_NUM)) begin
                        tgt_r <= vec_tab[cmd.irq_idx]; // RQ4
                     end else begin
                        tgt_r <= vec_tab[0];
                     end
                     busy_r <= 1'b1;
                     state_r <= ST_PUSH_LOW;
                  end
                  PCBS_OP_RETURN: begin
                     req_r.addr <= sp_r; // RQ6
                     rd_r <= 1'b1;
                     busy_r <= 1'b1;
                     state_r <= ST_POP_HIGH;
                  end
                  default: pc_r <= pc_nxt; // RQ2 RQ5 RQ14
               endcase
            end
            ST_PUSH_LOW: begin
               req_r <= '{we: 1'b1, addr: sp_r + 16'h0001,
                          wdata: {bank_r, ret_addr_r[7:0]}}; // RQ12 RQ10
               state_r <= ST_PUSH_HIGH;
            end
            ST_PUSH_HIGH: begin
               req_r <= '{we: 1'b1, addr: sp_r + 16'h0002, wdata: ret_addr_r[16:8]}; // RQ12
               sp_r <= sp_r + 16'h0002; // RQ12
               pc_r <= tgt_r;
               // Vectors live in bank 0; the old bank is already in the low word
               if (irq_bank_clr_r) begin
                  bank_r <= 1'b0; // RQ4
               end
               busy_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            ST_POP_HIGH: begin
               req_r.addr <= sp_r - 16'h0001;
               rd_r <= 1'b1;
               state_r <= ST_POP_LOW;
            end
            ST_POP_LOW: begin
               high_r <= ram_rdata; // RQ6
               state_r <= ST_POP_DONE;
            end
            ST_POP_DONE: begin
               pc_r <= {high_r, ram_rdata[7:0]}; // RQ6
               bank_r <= ram_rdata[8]; // RQ6 RQ7
               sp_r <= sp_r - 16'h0002;
               busy_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            default: begin
               busy_r <= 1'b0;
               state_r <= ST_IDLE;
            end
         endcase
         // First enabled cycle after reset: the stored option picks the start
         if (!start_done_r) begin
            pc_r <= (HAS_START_OPTION && start_opt) ? RESET_VEC_ALT : RESET_VEC_LOW; // RQ3
         end
      end
   end

   // Remembers an interrupt entry until its push frame completes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_bank_clr_r <= 1'b0;
      end else if (clk_en) begin
         if (state_r == ST_IDLE) begin
            irq_bank_clr_r <= (cmd.op == PCBS_OP_IRQ);
         end
      end
   end

   // ************************************************************
   // Reset start address, caught after release
   // ************************************************************
   // The option is static storage, so one look after reset is enough
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_done_r <= 1'b0;
      end else if (clk_en) begin
         start_done_r <= 1'b1; // RQ3
      end
   end

   // ************************************************************
   // Lookup address and accumulator register
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         look_r <= 18'h00000;
         look_ram_r <= 16'h0000;
      end else if (clk_en) begin
         look_r <= {bank_r, lookup_pair}; // RQ9
         look_ram_r <= {9'h000, lookup_reg, 1'b0} & IND_REG_TOP; // RQ11
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_r <= ACC_RESET; // RQ13
         rdata_r <= 8'h00;
      end else if (clk_en) begin
         if (bus_wr && bus_addr == ACC_ADDR) begin
            acc_r <= bus_wdata; // RQ13
         end
         rdata_r <= (bus_rd && bus_addr == ACC_ADDR) ? acc_r : 8'h00;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   logic [16:0] pc_out_r;
   logic bank_out_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_out_r <= RESET_VEC_LOW;
         bank_out_r <= 1'b0;
      end else if (clk_en) begin
         pc_out_r <= pc_r;
         bank_out_r <= bank_r;
      end
   end

   assign pc = pc_out_r; // RQ1
   assign bank_flag = bank_out_r;
   assign ram_req = req_r;
   assign ram_rd = rd_r;
   assign busy = busy_r;
   assign rom_lookup_addr = look_r;
   assign lookup_ram_addr = look_ram_r;
   assign accumulator = acc_r;
   assign bus_rdata = rdata_r;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_start_address: assert property ( // RQ3
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && !start_done_r) |=>
         (pc_r == ((HAS_START_OPTION && $past(start_opt)) ? RESET_VEC_ALT : RESET_VEC_LOW)
          && !bank_r)
   ) else $error("start address or bank wrong after reset");

   a_step_advance: assert property ( // RQ2
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && start_done_r && state_r == ST_IDLE && cmd.op == PCBS_OP_STEP) |=>
         (pc_r == $past(pc_r) + 17'($past(cmd.nbytes)) && $stable(bank_r))
   ) else $error("plain step did not advance by its byte count");

   a_branch_bank: assert property ( // RQ5 RQ14
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state_r == ST_IDLE
       && cmd.op inside {PCBS_OP_BRANCH, PCBS_OP_JUMP_ABS, PCBS_OP_JUMP_REL}) |=> $stable(bank_r)
   ) else $error("branch or jump changed the bank");

   a_call_target: assert property ( // RQ14
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state_r == ST_PUSH_HIGH && !irq_bank_clr_r) |=>
         (pc_r == $past(tgt_r) && $stable(bank_r))
   ) else $error("call did not load its target in the same bank");

   a_irq_bank_zero: assert property ( // RQ4
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state_r == ST_PUSH_HIGH && irq_bank_clr_r) |=>
         (pc_r == $past(tgt_r) && !bank_r)
   ) else $error("interrupt entry did not land on its bank 0 vector");

   a_push_low_word: assert property ( // RQ12
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state_r == ST_PUSH_LOW) |=> (ram_req.we && ram_req.addr == sp_r + 16'h0001
         && ram_req.wdata == {bank_r, ret_addr_r[7:0]})
   ) else $error("bank and low address byte not written at stack plus one");

   a_push_high_word: assert property ( // RQ12
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state_r == ST_PUSH_HIGH) |=> (ram_req.we && ram_req.addr == sp_r
         && ram_req.wdata == ret_addr_r[16:8] && sp_r == $past(sp_r) + 16'h0002)
   ) else $error("high address bits not written at stack plus two");

   a_return_restore: assert property ( // RQ6
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state_r == ST_POP_DONE) |=>
         ({bank_r, pc_r[7:0]} == $past(ram_rdata) && pc_r[16:8] == high_r)
   ) else $error("return did not restore address and bank from the stack");

   a_acc_write: assert property ( // RQ13
      @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && bus_wr && bus_addr == ACC_ADDR) |=> (accumulator == $past(bus_wdata))
   ) else $error("accumulator write lost");

   a_lookup_bank: assert property ( // RQ9
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en |=> (rom_lookup_addr == {$past(bank_r), $past(lookup_pair)})
   ) else $error("table lookup address left the current bank");

   a_stack_nine_bit: assert property ( // RQ10
      @(posedge ref_clk) disable iff (!rst_b)
      ram_req.we |-> (ram_req.addr <= RAM9_TOP)
   ) else $error("stack write outside the nine-bit RAM area");

   // Main scenarios
   c_call_entry: cover property (
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && state_r == ST_PUSH_HIGH && !irq_bank_clr_r
   );

   c_irq_entry: cover property (
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && state_r == ST_PUSH_HIGH && irq_bank_clr_r
   );

   c_bank_switch: cover property (
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && state_r == ST_POP_DONE && ram_rdata[8]
   );

   c_alt_start: cover property (
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && !start_done_r && start_opt
   );
endmodule : pcbs_sequencer

// ===== pcbs_stack_ram.sv
`timescale 1ns/1ps
module pcbs_stack_ram import pcbs_pkg::*; (
   input wire logic ref_clk, // Core clock
   input wire pcbs_ram_req_type ram_req, // Request from the sequencer
   input wire logic ram_rd, // Read strobe
   output logic [8:0] ram_rdata // Word, valid one cycle after the strobe
);
   // ************************************************************
   // Nine-bit stack RAM, plain always so the bench may preload words
   // ************************************************************
   logic [8:0] mem [0:65535];
   logic [15:0] last_wa;
   logic [15:0] prev_wa;
   always @(posedge ref_clk) begin
      if (ram_req.we) begin
         mem[ram_req.addr] <= ram_req.wdata;
         prev_wa <= last_wa;
         last_wa <= ram_req.addr;
      end
      // Data only valid in its one cycle; inverting exposes late sampling
      if (ram_rd) begin
         ram_rdata <= mem[ram_req.addr];
      end else begin
         ram_rdata <= ~ram_rdata;
      end
   end
endmodule : pcbs_stack_ram

// ===== pcbs_sequencer_bench.sv
`timescale 1ns/1ps
module pcbs_sequencer_bench import pcbs_pkg::*;;
   // ************************************************************
   // Stimulus and observation
   // ************************************************************
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic start_opt = 1'b0;
   pcbs_cmd_type cmd = '0;
   logic [5:0] lookup_reg = 6'h00;
   logic [15:0] bus_addr = 16'h0000;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [16:0] lookup_pair = 17'h00000;
   logic [7:0] bus_rdata, accumulator, rd;
   logic [16:0] pc, e;
   logic bank_flag, ram_rd, busy;
   pcbs_ram_req_type ram_req;
   logic [8:0] ram_rdata;
   logic [17:0] rom_lookup_addr;
   logic [15:0] lookup_ram_addr;
   int n_mismatch = 0;
   int total_checks = 0;
   logic opt_hit = 1'b0;

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   // Code must never run from the reserved option bytes of bank 0
   always @(posedge ref_clk) begin
      if (rst_b && !bank_flag && pc >= OPT_AREA_LO && pc <= OPT_AREA_HI) begin
         opt_hit <= 1'b1;
      end
   end

   pcbs_sequencer i_pcbs_sequencer (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
      .start_opt(start_opt), .cmd(cmd), .ram_rdata(ram_rdata), .lookup_reg(lookup_reg),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .lookup_pair(lookup_pair), .bus_rdata(bus_rdata), .pc(pc), .bank_flag(bank_flag),
      .ram_req(ram_req), .ram_rd(ram_rd), .busy(busy), .rom_lookup_addr(rom_lookup_addr),
      .lookup_ram_addr(lookup_ram_addr), .accumulator(accumulator));
   pcbs_stack_ram i_pcbs_stack_ram (.ref_clk(ref_clk), .ram_req(ram_req), .ram_rd(ram_rd),
      .ram_rdata(ram_rdata));

   task complete_run;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   task check(string what, logic [17:0] seen, logic [17:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task do_reset(logic opt);
      rst_b <= 1'b0;
      start_opt <= opt;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : do_reset

   task bwr(logic [15:0] a, logic [7:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask : bwr

   task brd(logic [15:0] a);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 rd = bus_rdata;
   endtask : brd

   // Commands last one cycle; pushes and pops are awaited on busy, bounded
   task send(pcbs_op_type o, logic [2:0] nb, logic [16:0] tg, logic [11:0] d12,
             logic [7:0] d8, logic [3:0] ix, logic tk);
      int i;
      @(posedge ref_clk);
      cmd <= '{op: o, nbytes: nb, disp8: d8, disp12: d12, target: tg, irq_idx: ix, taken: tk};
      @(posedge ref_clk);
      cmd <= '0;
      #1 i = 0;
      while (busy !== 1'b0 && i < 20) begin
         @(posedge ref_clk);
         #1 i++;
      end
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : send

   initial begin
      #(20 * 5000);
      n_mismatch++;
      complete_run();
   end

   initial begin
      do_reset(1'b0);
      check("pc", pc, RESET_VEC_LOW);
      check("bank", bank_flag, 0);
      check("acc", accumulator, ACC_RESET);
      brd(ACC_ADDR);
      check("acc read", rd, ACC_RESET);
      do_reset(1'b1);
      check("alt pc", pc, RESET_VEC_ALT);
      bwr(ACC_ADDR, 8'hc5);
      bwr(16'hfe01, 8'h3a);
      brd(ACC_ADDR);
      check("acc read", rd, 8'hc5);
      e = RESET_VEC_ALT;
      for (int n = 1; n <= 3; n++) begin
         send(PCBS_OP_STEP, n[2:0], 17'h0, 12'h0, 8'h0, 4'h0, 1'b1);
         e = e + 17'(n);
         check("step pc", pc, e);
      end
      @(posedge ref_clk);
      clk_en <= 1'b0;
      send(PCBS_OP_STEP, 3'd2, 17'h0, 12'h0, 8'h0, 4'h0, 1'b1);
      check("frozen pc", pc, e);
      clk_en <= 1'b1;
      send(PCBS_OP_JUMP_ABS, 3'd3, 17'h10000, 12'h0, 8'h0, 4'h0, 1'b1);
      check("jump pc", pc, 17'h10000);
      send(PCBS_OP_JUMP_REL, 3'd2, 17'h0, 12'h800, 8'h0, 4'h0, 1'b1);
      e = 17'h10002 - 17'd2048;
      check("rel jump pc", pc, e);
      send(PCBS_OP_CALL_REL, 3'd2, 17'h0, 12'h7ff, 8'h0, 4'h0, 1'b1);
      e = e + 17'd2 + 17'd2047;
      check("rel call pc", pc, e);
      check("push low at", i_pcbs_stack_ram.prev_wa, 16'h0001);
      check("push high at", i_pcbs_stack_ram.last_wa, 16'h0002);
      check("pushed bank", i_pcbs_stack_ram.mem[1][8], 0);
      send(PCBS_OP_CALL_ACC, 3'd1, 17'h0, 12'h0, 8'h0, 4'h0, 1'b1);
      e = e + 17'd1 + 17'hc5;
      check("acc call pc", pc, e);
      // Bank switch: overwrite the saved return frame, then return
      i_pcbs_stack_ram.mem[4] = 9'h012;
      i_pcbs_stack_ram.mem[3] = 9'h134;
      send(PCBS_OP_RETURN, 3'd1, 17'h0, 12'h0, 8'h0, 4'h0, 1'b1);
      check("ret pc", pc, 17'h01234);
      check("ret bank", bank_flag, 1);
      lookup_pair <= 17'h1abcd;
      lookup_reg <= 6'd63;
      send(PCBS_OP_STEP, 3'd3, 17'h0, 12'h0, 8'h0, 4'h0, 1'b1);
      check("step bank", bank_flag, 1);
      check("lookup rom", rom_lookup_addr, 18'h3abcd);
      check("lookup ram", lookup_ram_addr, 16'h007e);
      e = 17'h01237;
      send(PCBS_OP_BRANCH, 3'd2, 17'h0, 12'h0, 8'hf0, 4'h0, 1'b1);
      e = e + 17'd2 - 17'd16;
      check("branch back", pc, e);
      send(PCBS_OP_BRANCH, 3'd3, 17'h0, 12'h0, 8'h7f, 4'h0, 1'b1);
      e = e + 17'd3 + 17'd127;
      check("branch fwd", pc, e);
      check("branch bank", bank_flag, 1);
      send(PCBS_OP_BRANCH, 3'd2, 17'h0, 12'h0, 8'h7f, 4'h0, 1'b0);
      check("not taken", pc, e + 17'd2);
      for (int i = 0; i < 10; i++) begin
         send(PCBS_OP_IRQ, 3'd1, 17'h0, 12'h0, 8'h0, 4'(i), 1'b1);
         check("irq pc", pc, 17'h00003 + 17'(8 * i));
         check("irq bank", bank_flag, 0);
      end
      check("option area", opt_hit, 0);
      complete_run();
   end
endmodule : pcbs_sequencer_bench
